// ### inc/ddrpd_pkg.sv
// Purpose: Shared constants and types for the DDR2 command, precharge and power-down block.
// Assumes: Pins are sampled by the system clock; the memory clock arrives as an ordinary pin.
// Notes: Command codes are {chip-select, row-strobe, column-strobe, write-enable}, active low.
package ddrpd_pkg;
   // ==========================================================================
   // Sizes
   localparam int NUM_BANKS = 4;
   localparam int BA_W = 2;
   localparam int CNT_W = 6;
   localparam int REFA_W = 13;

   // ==========================================================================
   // Command encodings
   localparam logic [3:0] CODE_MODE_SET = 4'h0;
   localparam logic [3:0] CODE_REF = 4'h1;
   localparam logic [3:0] CODE_PRE = 4'h2;
   localparam logic [3:0] CODE_ACT = 4'h3;
   localparam logic [3:0] CODE_WR = 4'h4;
   localparam logic [3:0] CODE_RD = 4'h5;
   localparam logic [3:0] CODE_NOP = 4'h7;

   // ==========================================================================
   // Burst halves and reset values
   localparam logic [CNT_W-1:0] HALF_BURST4 = 6'h02;
   localparam logic [CNT_W-1:0] HALF_BURST8 = 6'h04;
   localparam logic [NUM_BANKS-1:0] RST_BANK_OPEN = 4'h0;
   localparam logic [REFA_W-1:0] RST_REF_ADDR = 13'h0000;
   localparam logic RST_DLL_EN = 1'b1;
   localparam logic RST_INBUF_EN = 1'b1;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {PD_NONE, PD_PRE, PD_ACT, PD_SELF} ddrpd_pd_e;

   typedef struct packed {
      logic ck;
      logic cke;
      logic [3:0] cmd;
      logic ap_bit;
      logic [BA_W-1:0] ba;
      logic term;
   } ddrpd_pins_s;
endpackage

// ### inc/ddrpd_bank_if.sv
// Purpose: Per-bank command strobes and status between the decoder and a bank tracker.
// Assumes: Strobes are valid only in the system cycle flagged by ck_edge.
// Notes: One instance per bank.
`timescale 1ns/1ns
interface ddrpd_bank_if (
   input wire logic clk
);
   logic ck_edge;
   logic act;
   logic pre;
   logic wr_ap;
   logic [ddrpd_pkg::CNT_W-1:0] ap_delay;
   logic [ddrpd_pkg::CNT_W-1:0] pre_period_cyc;
   logic open;
   logic busy;

   modport ctrl (
      output ck_edge, act, pre, wr_ap, ap_delay, pre_period_cyc,
      input open, busy
   );
   modport bank (
      input ck_edge, act, pre, wr_ap, ap_delay, pre_period_cyc,
      output open, busy
   );
endinterface

// ### src/ddrpd_bank.sv
// Purpose: Tracks one bank: open row, pending write auto-precharge, precharge period.
// Assumes: Counts are in memory clock edges, signalled by ck_edge.
// Notes: An explicit precharge cancels a pending auto-precharge and restarts the period.
`timescale 1ns/1ns
module ddrpd_bank (
   input wire logic clk,
   input wire logic rstn,
   ddrpd_bank_if.bank b
);
   logic open_r, open_nxt;
   logic ap_pend_r, ap_pend_nxt;
   logic [ddrpd_pkg::CNT_W-1:0] ap_cnt_r, ap_cnt_nxt;
   logic [ddrpd_pkg::CNT_W-1:0] pre_cnt_r, pre_cnt_nxt;

   // ==========================================================================
   // Next state
   always_comb begin
      open_nxt = open_r;
      ap_pend_nxt = ap_pend_r;
      ap_cnt_nxt = ap_cnt_r;
      pre_cnt_nxt = pre_cnt_r;
      if (b.ck_edge) begin
         if (pre_cnt_r != '0) begin
            pre_cnt_nxt = pre_cnt_r - 6'h01;
         end
         if (ap_pend_r) begin
            if (ap_cnt_r <= 6'h01) begin
               open_nxt = 1'b0;
               ap_pend_nxt = 1'b0;
               pre_cnt_nxt = b.pre_period_cyc;
            end else begin
               ap_cnt_nxt = ap_cnt_r - 6'h01;
            end
         end
         if (b.act) begin
            open_nxt = 1'b1;
         end
         if (b.wr_ap) begin
            ap_pend_nxt = 1'b1;
            ap_cnt_nxt = b.ap_delay;
         end
         if (b.pre) begin
            open_nxt = 1'b0;
            ap_pend_nxt = 1'b0;
            pre_cnt_nxt = b.pre_period_cyc;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         open_r <= 1'b0;
         ap_pend_r <= 1'b0;
         ap_cnt_r <= '0;
         pre_cnt_r <= '0;
      end else begin
         open_r <= open_nxt;
         ap_pend_r <= ap_pend_nxt;
         ap_cnt_r <= ap_cnt_nxt;
         pre_cnt_r <= pre_cnt_nxt;
      end
   end

   assign b.open = open_r;
   assign b.busy = ap_pend_r | (pre_cnt_r != '0);

   // ==========================================================================
   // Checks
   property p_ap_close;
      @(posedge clk) disable iff (!rstn)
      b.ck_edge && ap_pend_r && ap_cnt_r == 6'h01 && !b.act && !b.pre && !b.wr_ap
         |=> !open_r && !ap_pend_r && pre_cnt_r == $past(b.pre_period_cyc);
   endproperty
   a_ap_close: assert property (p_ap_close) else $error("auto-precharge did not close bank");

   property p_pre_restart;
      @(posedge clk) disable iff (!rstn)
      b.ck_edge && b.pre |=> !open_r && pre_cnt_r == $past(b.pre_period_cyc);
   endproperty
   a_pre_restart: assert property (p_pre_restart) else $error("precharge period not restarted");
endmodule

// ### src/ddrpd_top.sv
// Purpose: Command decode, bank tracking, refresh and power-down control of a four-bank DDR2 core.
// Assumes: All pins, the memory clock included, come from outside and are synchronised here.
// Notes: Latency and recovery settings arrive as plain configuration ports in memory clocks.
`timescale 1ns/1ns
module ddrpd_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ck_pin,
   input wire logic cke_pin,
   input wire logic cs_n_pin,
   input wire logic ras_n_pin,
   input wire logic cas_n_pin,
   input wire logic we_n_pin,
   input wire logic autoprecharge_addr_bit_pin,
   input wire logic [ddrpd_pkg::BA_W-1:0] ba_pin,
   input wire logic termination_enable_pin,
   input wire logic [ddrpd_pkg::CNT_W-1:0] cfg_write_latency,
   input wire logic cfg_burst_len8,
   input wire logic [ddrpd_pkg::CNT_W-1:0] cfg_write_recovery,
   input wire logic [ddrpd_pkg::CNT_W-1:0] cfg_precharge_period,
   input wire logic cfg_slow_exit,
   output logic [ddrpd_pkg::NUM_BANKS-1:0] bank_open,
   output ddrpd_pkg::ddrpd_pd_e pd_state,
   output logic dll_en,
   output logic inbuf_en,
   output logic termination_active,
   output logic [ddrpd_pkg::REFA_W-1:0] refresh_addr,
   output logic refresh_pulse,
   output logic mode_reg_write,
   output logic [ddrpd_pkg::BA_W-1:0] mode_reg_sel,
   output logic cmd_illegal
);
   // ==========================================================================
   // Pin synchroniser
   ddrpd_pkg::ddrpd_pins_s pin_w, sync1_r, sync2_r;
   logic ck_prev_r;
   logic ck_edge;

   assign pin_w = '{ck: ck_pin, cke: cke_pin,
                    cmd: {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin},
                    ap_bit: autoprecharge_addr_bit_pin, ba: ba_pin, term: termination_enable_pin};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         ck_prev_r <= 1'b0;
      end else begin
         sync1_r <= pin_w;
         sync2_r <= sync1_r;
         ck_prev_r <= sync2_r.ck;
      end
   end

   // The memory clock is slow against clk, so its rising edge is found by sampling.
   assign ck_edge = sync2_r.ck & ~ck_prev_r;

   // ==========================================================================
   // Command decode
   logic cke_prev_r, cke_prev_nxt;
   logic sel, is_idle_cmd, run;
   logic [ddrpd_pkg::CNT_W-1:0] half_burst, ap_delay;
   logic [ddrpd_pkg::NUM_BANKS-1:0] open_w, busy_w, act_v, pre_v, wrap_v;

   assign sel = ~sync2_r.cmd[3];
   assign is_idle_cmd = ~sel | (sync2_r.cmd == ddrpd_pkg::CODE_NOP);
   assign run = ck_edge & cke_prev_r & sync2_r.cke & (pd_state == ddrpd_pkg::PD_NONE);
   assign half_burst = cfg_burst_len8 ? ddrpd_pkg::HALF_BURST8 : ddrpd_pkg::HALF_BURST4;
   assign ap_delay = cfg_write_latency + half_burst + cfg_write_recovery;

   always_comb begin
      act_v = '0;
      pre_v = '0;
      wrap_v = '0;
      if (run && sel) begin
         case (sync2_r.cmd)
            ddrpd_pkg::CODE_ACT: act_v[sync2_r.ba] = 1'b1;
            ddrpd_pkg::CODE_PRE: begin
               if (sync2_r.ap_bit) begin
                  pre_v = '1;
               end else begin
                  pre_v[sync2_r.ba] = 1'b1;
               end
            end
            ddrpd_pkg::CODE_WR: wrap_v[sync2_r.ba] = sync2_r.ap_bit;
            default: ;
         endcase
      end
   end

   // ==========================================================================
   // Bank trackers
   for (genvar i = 0; i < ddrpd_pkg::NUM_BANKS; i++) begin : g_bank
      ddrpd_bank_if bif (.clk(clk));
      assign bif.ck_edge = ck_edge;
      assign bif.act = act_v[i];
      assign bif.pre = pre_v[i];
      assign bif.wr_ap = wrap_v[i];
      assign bif.ap_delay = ap_delay;
      assign bif.pre_period_cyc = cfg_precharge_period;
      assign open_w[i] = bif.open;
      assign busy_w[i] = bif.busy;
      ddrpd_bank u_bank (
         .clk(clk),
         .rstn(rstn),
         .b(bif.bank)
      );
   end

   // ==========================================================================
   // Power-down, refresh and mode register control
   ddrpd_pkg::ddrpd_pd_e pd_nxt;
   logic [ddrpd_pkg::NUM_BANKS-1:0] bank_open_nxt;
   logic dll_en_nxt, inbuf_en_nxt, term_nxt, refresh_nxt, mrw_nxt, illegal_nxt;
   logic [ddrpd_pkg::REFA_W-1:0] refresh_addr_nxt;
   logic [ddrpd_pkg::BA_W-1:0] mode_reg_sel_nxt;

   always_comb begin
      pd_nxt = pd_state;
      cke_prev_nxt = ck_edge ? sync2_r.cke : cke_prev_r;
      refresh_addr_nxt = refresh_addr;
      refresh_nxt = 1'b0;
      mrw_nxt = 1'b0;
      mode_reg_sel_nxt = mode_reg_sel;
      illegal_nxt = 1'b0;
      case (pd_state)
         ddrpd_pkg::PD_NONE: begin
            if (ck_edge && cke_prev_r && !sync2_r.cke) begin
               if (sel && sync2_r.cmd == ddrpd_pkg::CODE_REF) begin
                  pd_nxt = ddrpd_pkg::PD_SELF;
                  illegal_nxt = |open_w;
               end else if (is_idle_cmd) begin
                  pd_nxt = (|open_w) ? ddrpd_pkg::PD_ACT : ddrpd_pkg::PD_PRE;
               end else begin
                  illegal_nxt = 1'b1;
               end
            end else if (run && sel) begin
               case (sync2_r.cmd)
                  ddrpd_pkg::CODE_REF: begin
                     refresh_addr_nxt = refresh_addr + 13'h0001;
                     refresh_nxt = 1'b1;
                     illegal_nxt = |(open_w | busy_w);
                  end
                  ddrpd_pkg::CODE_MODE_SET: begin
                     mrw_nxt = 1'b1;
                     mode_reg_sel_nxt = sync2_r.ba;
                  end
                  ddrpd_pkg::CODE_ACT: illegal_nxt = open_w[sync2_r.ba];
                  ddrpd_pkg::CODE_RD, ddrpd_pkg::CODE_WR: illegal_nxt = ~open_w[sync2_r.ba];
                  ddrpd_pkg::CODE_PRE, ddrpd_pkg::CODE_NOP: ;
                  default: illegal_nxt = 1'b1;
               endcase
            end
         end
         ddrpd_pkg::PD_PRE, ddrpd_pkg::PD_ACT: begin
            // Commands are not executed here; the gate and clock decide exit, termination follows its pin, and a non-idle command on the exit edge is flagged.
            if (ck_edge && !cke_prev_r && sync2_r.cke) begin
               pd_nxt = ddrpd_pkg::PD_NONE;
               illegal_nxt = ~is_idle_cmd;
            end
         end
         ddrpd_pkg::PD_SELF: begin
            // Exit needs no clock edge, since the memory clock may be stopped here.
            if (sync2_r.cke) begin
               pd_nxt = ddrpd_pkg::PD_NONE;
               cke_prev_nxt = 1'b1;
            end
         end
         default: pd_nxt = ddrpd_pkg::PD_NONE;
      endcase
      inbuf_en_nxt = (pd_nxt == ddrpd_pkg::PD_NONE);
      dll_en_nxt = !(pd_nxt == ddrpd_pkg::PD_PRE || pd_nxt == ddrpd_pkg::PD_SELF
                     || (pd_nxt == ddrpd_pkg::PD_ACT && cfg_slow_exit));
      term_nxt = sync2_r.term && (pd_nxt != ddrpd_pkg::PD_SELF);
      bank_open_nxt = open_w;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pd_state <= ddrpd_pkg::PD_NONE;
         cke_prev_r <= 1'b0;
         bank_open <= ddrpd_pkg::RST_BANK_OPEN;
         dll_en <= ddrpd_pkg::RST_DLL_EN;
         inbuf_en <= ddrpd_pkg::RST_INBUF_EN;
         termination_active <= 1'b0;
         refresh_addr <= ddrpd_pkg::RST_REF_ADDR;
         refresh_pulse <= 1'b0;
         mode_reg_write <= 1'b0;
         mode_reg_sel <= '0;
         cmd_illegal <= 1'b0;
      end else begin
         pd_state <= pd_nxt;
         cke_prev_r <= cke_prev_nxt;
         bank_open <= bank_open_nxt;
         dll_en <= dll_en_nxt;
         inbuf_en <= inbuf_en_nxt;
         termination_active <= term_nxt;
         refresh_addr <= refresh_addr_nxt;
         refresh_pulse <= refresh_nxt;
         mode_reg_write <= mrw_nxt;
         mode_reg_sel <= mode_reg_sel_nxt;
         cmd_illegal <= illegal_nxt;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_pd_entry;
      pd_state == ddrpd_pkg::PD_NONE && ck_edge && cke_prev_r && !sync2_r.cke && is_idle_cmd;
   endsequence

   property p_pd_type;
      s_pd_entry |=> pd_state == ($past(|open_w) ? ddrpd_pkg::PD_ACT : ddrpd_pkg::PD_PRE);
   endproperty
   a_pd_type: assert property (p_pd_type) else $error("wrong power-down type");

   property p_pd_dll;
      pd_state == ddrpd_pkg::PD_PRE |-> !dll_en;
   endproperty
   a_pd_dll: assert property (p_pd_dll) else $error("loop enabled in precharge power-down");

   property p_inbuf;
      s_pd_entry |=> !inbuf_en ##1 (!inbuf_en || pd_state == ddrpd_pkg::PD_NONE);
   endproperty
   a_inbuf: assert property (p_inbuf) else $error("buffers left on in power-down");

   property p_act_opens;
      run && sel && sync2_r.cmd == ddrpd_pkg::CODE_ACT |-> ##2 bank_open[$past(sync2_r.ba, 2)];
   endproperty
   a_act_opens: assert property (p_act_opens) else $error("activate did not open bank");

   property p_self_exit;
      pd_state == ddrpd_pkg::PD_SELF && sync2_r.cke |=> pd_state == ddrpd_pkg::PD_NONE && inbuf_en;
   endproperty
   a_self_exit: assert property (p_self_exit) else $error("self refresh exit missed");

   property p_mrs_sel;
      run && sel && sync2_r.cmd == ddrpd_pkg::CODE_MODE_SET
         |=> mode_reg_write && mode_reg_sel == $past(sync2_r.ba);
   endproperty
   a_mrs_sel: assert property (p_mrs_sel) else $error("mode register select wrong");

   property p_ref_count;
      run && sel && sync2_r.cmd == ddrpd_pkg::CODE_REF
         |=> refresh_pulse && refresh_addr == $past(refresh_addr) + 13'h0001;
   endproperty
   a_ref_count: assert property (p_ref_count) else $error("refresh counter did not step");
endmodule

// ### verif/ddrpd_ctrl_model.sv
// Purpose: Controller-side model that makes the memory clock and issues one command per call.
// Assumes: Each issued command is followed by a no-operation edge.
// Notes: Pins change shortly after the falling memory clock edge, far from the sampling edge.
`timescale 1ns/1ns
module ddrpd_ctrl_model (
   input wire logic clk,
   output logic ck_pin,
   output logic cke_pin,
   output logic cs_n_pin,
   output logic ras_n_pin,
   output logic cas_n_pin,
   output logic we_n_pin,
   output logic autoprecharge_addr_bit_pin,
   output logic [ddrpd_pkg::BA_W-1:0] ba_pin
);
   // =========================================================================
   // Pending command
   logic cke_q = 1'b1;
   logic [3:0] code_q = ddrpd_pkg::CODE_NOP;
   logic ap_q = 1'b0;
   logic [ddrpd_pkg::BA_W-1:0] ba_q = 2'h0;

   // =========================================================================
   // Memory clock
   int ck_hi = 63;
   int ck_lo = 62;

   // The clock keeps running in power-down, since the device needs it to see the exit.
   initial begin
      ck_pin = 1'b0;
      cke_pin = 1'b1;
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = ddrpd_pkg::CODE_NOP;
      autoprecharge_addr_bit_pin = 1'b0;
      ba_pin = 2'h0;
      forever begin
         #(ck_hi) ck_pin = 1'b1;
         #(ck_lo) ck_pin = 1'b0;
      end
   end

   // =========================================================================
   // Pin driver
   // Half a period of set-up and hold around each rising edge covers the synchroniser delay.
   always @(negedge ck_pin) begin
      @(posedge clk);
      #1;
      cke_pin = cke_q;
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = code_q;
      autoprecharge_addr_bit_pin = ap_q;
      ba_pin = ba_q;
      code_q = ddrpd_pkg::CODE_NOP;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge ck_pin);
      @(posedge clk);
      #2;
   endtask

   task automatic issue(input logic cke, input logic [3:0] code, input logic ap,
                        input logic [ddrpd_pkg::BA_W-1:0] ba);
      cke_q = cke;
      code_q = code;
      ap_q = ap;
      ba_q = ba;
      idle(2);
   endtask

   // The period may only change while the device sits in precharge power-down.
   task automatic set_ck(input int hi, input int lo);
      ck_hi = hi;
      ck_lo = lo;
   endtask
endmodule

// ### verif/tb_ddrpd_top.sv
// Purpose: Self-checking bench for command decode, precharge, refresh and power-down.
// Assumes: Write latency 2, write recovery 3 and precharge period 4 memory clocks.
// Notes: Pulses are counted on the falling system clock, so no edge race can hide them.
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
$display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module tb_ddrpd_top;
   localparam logic [3:0] MSET = ddrpd_pkg::CODE_MODE_SET;
   localparam logic [3:0] REF = ddrpd_pkg::CODE_REF;
   localparam logic [3:0] PRE = ddrpd_pkg::CODE_PRE;
   localparam logic [3:0] ACT = ddrpd_pkg::CODE_ACT;
   localparam logic [3:0] WR = ddrpd_pkg::CODE_WR;
   localparam logic [3:0] RD = ddrpd_pkg::CODE_RD;
   localparam logic [3:0] NOP = ddrpd_pkg::CODE_NOP;
   localparam logic [3:0] DSEL = 4'hf;
   // Read-to-precharge time in whole memory clocks, always rounded up.
   localparam int RD_PRE_NS = 150;
   localparam int CK_NS = 125;
   localparam int RD_PRE_CYC = (RD_PRE_NS + CK_NS - 1) / CK_NS;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, autoprecharge_addr_bit_pin;
   logic [ddrpd_pkg::BA_W-1:0] ba_pin;
   logic termination_enable_pin = 1'b1;
   logic [ddrpd_pkg::CNT_W-1:0] cfg_write_latency = 6'h02;
   logic [ddrpd_pkg::CNT_W-1:0] cfg_write_recovery = 6'h03;
   logic [ddrpd_pkg::CNT_W-1:0] cfg_precharge_period = 6'h04;
   logic cfg_burst_len8 = 1'b0;
   logic cfg_slow_exit = 1'b0;
   logic [ddrpd_pkg::NUM_BANKS-1:0] bank_open;
   ddrpd_pkg::ddrpd_pd_e pd_state;
   logic dll_en, inbuf_en, termination_active, refresh_pulse, mode_reg_write, cmd_illegal;
   logic [ddrpd_pkg::REFA_W-1:0] refresh_addr;
   logic [ddrpd_pkg::BA_W-1:0] mode_reg_sel;
   int n_errors = 0;
   int check_count = 0;
   int mrw_n = 0;
   int ref_n = 0;
   int ill_n = 0;

   ddrpd_top ddrpd_top_inst (.clk, .rstn, .ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin,
      .we_n_pin, .autoprecharge_addr_bit_pin, .ba_pin, .termination_enable_pin,
      .cfg_write_latency, .cfg_burst_len8, .cfg_write_recovery, .cfg_precharge_period,
      .cfg_slow_exit, .bank_open, .pd_state, .dll_en, .inbuf_en, .termination_active,
      .refresh_addr, .refresh_pulse, .mode_reg_write, .mode_reg_sel, .cmd_illegal);
   ddrpd_ctrl_model ddrpd_ctrl_model_inst (.clk, .ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin,
      .cas_n_pin, .we_n_pin, .autoprecharge_addr_bit_pin, .ba_pin);

   // =========================================================================
   // Clock and pulse counters
   initial begin
      forever #4 clk = ~clk;
   end
   always @(negedge clk) begin
      if (mode_reg_write === 1'b1)
         mrw_n++;
      if (refresh_pulse === 1'b1)
         ref_n++;
      if (cmd_illegal === 1'b1)
         ill_n++;
   end

   task automatic cmd(input logic cke, input logic [3:0] code, input logic ap,
                      input logic [1:0] ba);
      ddrpd_ctrl_model_inst.issue(cke, code, ap, ba);
   endtask

   task automatic wait_ck(input int n);
      ddrpd_ctrl_model_inst.idle(n);
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // =========================================================================
   // Watchdog
   // The sequence needs about 20 us; a hang anywhere ends the run as a failure.
   initial begin
      #200000;
      n_errors++;
      print_verdict();
   end

   // =========================================================================
   // Test sequence
   initial begin
      int bill;
      int bref;
      logic [ddrpd_pkg::REFA_W-1:0] addr;
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      wait_ck(2);
      `CHK(bank_open, 4'h0)
      `CHK(pd_state, ddrpd_pkg::PD_NONE)
      `CHK(dll_en, 1'b1)
      `CHK(inbuf_en, 1'b1)
      `CHK(termination_active, 1'b1)
      for (int b = 0; b < 4; b++) begin
         bref = mrw_n;
         cmd(1'b1, MSET, 1'b0, b[1:0]);
         `CHK(mrw_n - bref, 1)
         `CHK(mode_reg_sel, b[1:0])
      end
      for (int b = 0; b < 4; b++) begin
         cmd(1'b1, ACT, 1'b0, b[1:0]);
         `CHK(bank_open, 4'((1 << (b + 1)) - 1))
      end
      bill = ill_n;
      cmd(1'b1, RD, 1'b0, 2'h3);
      `CHK(ill_n - bill, 0)
      // Additive latency is zero and the half burst is two here.
      wait_ck(2 + (RD_PRE_CYC > 2 ? RD_PRE_CYC : 2) - 2);
      cmd(1'b1, ACT, 1'b0, 2'h0);
      `CHK(ill_n - bill, 1)
      cmd(1'b1, PRE, 1'b0, 2'h1);
      `CHK(bank_open, 4'hd)
      cmd(1'b1, PRE, 1'b1, 2'h1);
      `CHK(bank_open, 4'h0)
      // A single-bank precharge restarts that bank's period, so the refresh is early.
      wait_ck(2);
      cmd(1'b1, PRE, 1'b0, 2'h0);
      bill = ill_n;
      cmd(1'b1, REF, 1'b0, 2'h0);
      `CHK(ill_n - bill, 1)
      wait_ck(4);
      bill = ill_n;
      bref = ref_n;
      addr = refresh_addr;
      cmd(1'b1, REF, 1'b0, 2'h0);
      `CHK(ref_n - bref, 1)
      `CHK(refresh_addr, addr + 13'h0001)
      cmd(1'b1, WR, 1'b0, 2'h3);
      cmd(1'b1, RD, 1'b0, 2'h3);
      `CHK(ill_n - bill, 2)
      for (int blen = 0; blen < 2; blen++) begin
         @(posedge clk);
         #1;
         cfg_burst_len8 = blen[0];
         cmd(1'b1, ACT, 1'b0, 2'h2);
         cmd(1'b1, WR, 1'b1, 2'h2);
         wait_ck(2 + (blen == 1 ? 4 : 2) + 3 - 1);
         `CHK(bank_open[2], 1'b1)
         wait_ck(1);
         `CHK(bank_open[2], 1'b0)
         wait_ck(4);
      end
      cmd(1'b1, ACT, 1'b0, 2'h2);
      cmd(1'b1, WR, 1'b0, 2'h2);
      wait_ck(10);
      `CHK(bank_open[2], 1'b1)
      cmd(1'b1, PRE, 1'b0, 2'h2);
      wait_ck(4);
      `CHK(dll_en, 1'b1)
      cmd(1'b0, NOP, 1'b0, 2'h0);
      `CHK(pd_state, ddrpd_pkg::PD_PRE)
      `CHK(dll_en, 1'b0)
      `CHK(inbuf_en, 1'b0)
      // Termination goes off first, then the memory clock is slowed and restored.
      @(posedge clk);
      #1;
      termination_enable_pin = 1'b0;
      wait_ck(2);
      `CHK(termination_active, 1'b0)
      ddrpd_ctrl_model_inst.set_ck(100, 100);
      wait_ck(3);
      `CHK(pd_state, ddrpd_pkg::PD_PRE)
      ddrpd_ctrl_model_inst.set_ck(63, 62);
      wait_ck(2);
      bill = ill_n;
      cmd(1'b0, ACT, 1'b0, 2'h0);
      `CHK(bank_open, 4'h0)
      `CHK(ill_n - bill, 0)
      cmd(1'b1, NOP, 1'b0, 2'h0);
      `CHK(pd_state, ddrpd_pkg::PD_NONE)
      `CHK(inbuf_en, 1'b1)
      wait_ck(2);
      bref = mrw_n;
      cmd(1'b1, MSET, 1'b0, 2'h0);
      `CHK(mrw_n - bref, 1)
      @(posedge clk);
      #1;
      termination_enable_pin = 1'b1;
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         #1;
         cfg_slow_exit = s[0];
         cmd(1'b1, ACT, 1'b0, 2'h1);
         cmd(1'b0, s[0] ? DSEL : NOP, 1'b0, 2'h0);
         `CHK(pd_state, ddrpd_pkg::PD_ACT)
         `CHK(dll_en, ~s[0])
         `CHK(termination_active, 1'b1)
         cmd(1'b1, NOP, 1'b0, 2'h0);
         `CHK(pd_state, ddrpd_pkg::PD_NONE)
         cmd(1'b1, PRE, 1'b0, 2'h1);
         wait_ck(4);
      end
      cmd(1'b0, REF, 1'b0, 2'h0);
      `CHK(pd_state, ddrpd_pkg::PD_SELF)
      `CHK(termination_active, 1'b0)
      `CHK(inbuf_en, 1'b0)
      cmd(1'b1, NOP, 1'b0, 2'h0);
      `CHK(pd_state, ddrpd_pkg::PD_NONE)
      wait_ck(2);
      @(posedge clk);
      #1;
      termination_enable_pin = 1'b0;
      wait_ck(1);
      `CHK(termination_active, 1'b0)
      print_verdict();
   end
endmodule
